//--- core/rosel_miss_track.sv
// Per-station missed-scan counters
`timescale 1ns/1ps
module rosel_miss_track (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Scan tick
    input wire logic scan_end_i,
    // Station status
    rosel_src_if.tracker src
);
    typedef struct packed {
        logic [2:0][1:0] miss;
        logic [2:0] seen;
    } rosel_trk_type;

    rosel_trk_type st;
    rosel_trk_type next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < rosel_pkg::NSRC; i++) begin
            if (src.fresh[i]) begin
                next_st.seen[i] = 1'b1;
            end
            if (scan_end_i) begin
                next_st.seen[i] = 1'b0;
                if (st.seen[i] || src.fresh[i]) begin
                    next_st.miss[i] = 2'h0;
                end else if (st.miss[i] != rosel_pkg::MISS_LIMIT) begin
                    next_st.miss[i] = st.miss[i] + 2'h1;
                end
            end
        end
        if (rst_i) begin
            next_st.seen = 3'h0;
            next_st.miss = {3{rosel_pkg::MISS_LIMIT}};
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    // Station lost only after three consecutive empty scans
    generate
        for (genvar g = 0; g < rosel_pkg::NSRC; g++) begin : g_pres
            assign src.present[g] = st.miss[g] != rosel_pkg::MISS_LIMIT;
        end
    endgenerate
endmodule

//--- core/rosel_pkg.sv
// Package for the redundant output source selector: constants, modes, register map
package rosel_pkg;
    localparam int NSRC = 3;
    localparam int NOUT = 16;
    localparam int CLK_HZ = 100_000_000;
    localparam int FAULT_DELAY_MS = 1000;
    localparam int FAULT_DELAY_CYC = CLK_HZ / 1000 * FAULT_DELAY_MS;
    localparam logic [1:0] MISS_LIMIT = 2'h3;
    localparam logic [4:0] STN_FIRST = 5'h1f;
    localparam logic [4:0] STN_SECOND = 5'h1e;
    localparam logic [4:0] STN_THIRD = 5'h1d;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DFLT = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_OUT = 4'hc;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_HOLD = 2;
    localparam int CTRL_TRIPLE = 3;
    localparam int CTRL_DC16 = 4;
    localparam int CTRL_FORCE = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] DFLT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        MODE_VOTED,
        MODE_FAILOVER,
        MODE_DUAL,
        MODE_NONE
    } rosel_mode_type;

    typedef enum logic [1:0] {
        SEL_FIRST,
        SEL_SECOND,
        SEL_THIRD,
        SEL_DEFAULT
    } rosel_sel_type;
endpackage

//--- core/rosel_src_if.sv
// Interface carrying per-station scan status between selector and tracker
`timescale 1ns/1ps
interface rosel_src_if;
    logic [2:0] fresh;
    logic [2:0] present;
    modport tracker (input fresh, output present);
    modport selector (output fresh, input present);
endinterface

//--- core/rosel_top.sv
// Redundant output source selector with Wishbone register slave
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module rosel_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Bus scan and station data, index 0 is station 31, 1 is 30, 2 is 29
    input wire logic scan_end_i,
    input wire logic [2:0] data_valid_i,
    input wire logic [47:0] data_i,
    // Raw circuit fault detections
    input wire logic [15:0] failed_switch_i,
    input wire logic [15:0] no_load_i,
    input wire logic [15:0] other_fault_i,
    // Outputs
    output logic [15:0] out_o,
    output logic unit_health_o,
    output logic [2:0] fault_report_o,
    output logic [15:0] fs_fault_o,
    output logic [15:0] nl_fault_o,
    output logic autotest_en_o,
    output logic [2:0] voter_in_o
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] dflt;
        logic [15:0] outs;
        logic [2:0] excl;
        logic [2:0] dv;
        logic [47:0] data;
        logic [15:0] fs_q;
        logic [15:0] nl_q;
        logic [26:0] fs_cnt;
        logic [26:0] nl_cnt;
        logic [15:0] fs_prev;
        logic [15:0] nl_prev;
        logic [2:0] rep;
        logic [15:0] rep_prev;
        logic [1:0] sel;
        logic ack;
        logic [31:0] rdat;
    } rosel_top_type;

    rosel_top_type st;
    rosel_top_type next_st;
    rosel_src_if src();

    localparam logic [26:0] DELAY = 27'(rosel_pkg::FAULT_DELAY_CYC);

    rosel_miss_track u_track (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scan_end_i(scan_end_i),
        .src(src)
    );

    assign src.fresh = data_valid_i;

    logic [1:0] mode;
    logic voted;
    logic triple;
    logic hold;
    logic dc16;
    logic force_logon_bit;
    logic [15:0] word [3];
    logic [15:0] vote;
    logic [2:0] usable;
    logic [1:0] sel;
    logic [15:0] fs_cur;
    logic [15:0] nl_cur;
    logic [15:0] any_fault;
    logic wb_hit;

    assign mode = st.ctrl[rosel_pkg::CTRL_MODE_LSB +: 2];
    assign voted = mode == rosel_pkg::MODE_VOTED;
    assign triple = st.ctrl[rosel_pkg::CTRL_TRIPLE];
    assign hold = st.ctrl[rosel_pkg::CTRL_HOLD];
    assign dc16 = st.ctrl[rosel_pkg::CTRL_DC16];
    assign force_logon_bit = st.ctrl[rosel_pkg::CTRL_FORCE];
    assign wb_hit = wb_cyc_i && wb_stb_i && !st.ack;

    generate
        for (genvar g = 0; g < rosel_pkg::NSRC; g++) begin : g_word
            assign word[g] = st.data[g*16 +: 16];
            // Matching sources or force logon may join the vote
            assign usable[g] = src.present[g] && !st.excl[g];
        end
    endgenerate

    // Bitwise majority, falling back to agreement of the remaining sources
    always_comb begin
        vote = st.outs;
        unique case (usable)
            3'h7: vote = (word[0] & word[1]) | (word[0] & word[2]) | (word[1] & word[2]);
            3'h3: vote = word[0] == word[1] ? word[0] : st.outs;
            3'h5: vote = word[0] == word[2] ? word[0] : st.outs;
            3'h6: vote = word[1] == word[2] ? word[1] : st.outs;
            3'h1: vote = word[0];
            3'h2: vote = word[1];
            3'h4: vote = word[2];
            default: vote = st.outs;
        endcase
    end

    // Priority pick among present stations, station 29 only when triple is set
    always_comb begin
        if (src.present[0]) begin
            sel = rosel_pkg::SEL_FIRST;
        end else if (src.present[1]) begin
            sel = rosel_pkg::SEL_SECOND;
        end else if (triple && src.present[2]) begin
            sel = rosel_pkg::SEL_THIRD;
        end else begin
            sel = rosel_pkg::SEL_DEFAULT;
        end
    end

    // Timed fault masks: in voted mode a raw switch fault must stand one second before reporting; no-load is delayed only with dc16, and then not in any_fault
    assign fs_cur = voted ? (st.fs_cnt >= DELAY ? st.fs_q : 16'h0000) : st.fs_q;
    assign nl_cur = (voted && dc16) ? (st.nl_cnt >= DELAY ? st.nl_q : 16'h0000) : st.nl_q;
    assign any_fault = fs_cur | other_fault_i | ((voted && dc16) ? 16'h0000 : nl_cur);

    always_comb begin
        next_st = st;
        next_st.dv = data_valid_i;
        for (int i = 0; i < rosel_pkg::NSRC; i++) begin
            if (data_valid_i[i]) begin
                next_st.data[i*16 +: 16] = data_i[i*16 +: 16];
            end
        end
        next_st.fs_q = failed_switch_i;
        next_st.nl_q = no_load_i;
        // Restart delay whenever the raw fault set changes
        if (failed_switch_i != st.fs_prev) begin
            next_st.fs_cnt = 27'h0;
        end else if (st.fs_cnt < DELAY) begin
            next_st.fs_cnt = st.fs_cnt + 27'h1;
        end
        if (no_load_i != st.nl_prev) begin
            next_st.nl_cnt = 27'h0;
        end else if (st.nl_cnt < DELAY) begin
            next_st.nl_cnt = st.nl_cnt + 27'h1;
        end
        next_st.fs_prev = failed_switch_i;
        next_st.nl_prev = no_load_i;

        if (voted) begin
            for (int i = 0; i < rosel_pkg::NSRC; i++) begin
                if (force_logon_bit || (st.dv[i] && word[i] == st.outs)) begin
                    next_st.excl[i] = 1'b0;
                end else if (st.dv[i] && word[i] != st.outs && usable != 3'h0 && !st.excl[i]
                             && usable != (3'h1 << i)) begin
                    next_st.excl[i] = 1'b1;
                end
            end
            next_st.outs = vote;
            next_st.sel = rosel_pkg::SEL_DEFAULT;
        end else begin
            next_st.excl = 3'h0;
            next_st.sel = sel;
            unique case (sel)
                rosel_pkg::SEL_FIRST: next_st.outs = word[0];
                rosel_pkg::SEL_SECOND: next_st.outs = word[1];
                rosel_pkg::SEL_THIRD: next_st.outs = word[2];
                rosel_pkg::SEL_DEFAULT: next_st.outs = hold ? st.outs : st.dflt;
            endcase
        end
        if (src.present == 3'h0 && voted) begin
            next_st.outs = hold ? st.outs : st.dflt;
        end

        // Event-driven directed fault report on any change of the fault set to a nonzero value
        next_st.rep_prev = any_fault;
        if (any_fault != st.rep_prev && any_fault != 16'h0000) begin
            next_st.rep = voted ? 3'h7 : 3'h1;
        end else begin
            next_st.rep = 3'h0;
        end

        // Wishbone classic: single-cycle ack, one idle cycle between
        next_st.ack = wb_hit;
        if (wb_hit && wb_we_i) begin
            if (wb_adr_i == rosel_pkg::REG_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        next_st.ctrl[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end else if (wb_adr_i == rosel_pkg::REG_DFLT) begin
                for (int b = 0; b < 2; b++) begin
                    if (wb_sel_i[b]) begin
                        next_st.dflt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end
        end
        // Force logon is a one-shot command
        if (st.ctrl[rosel_pkg::CTRL_FORCE] && !(wb_hit && wb_we_i && wb_adr_i == rosel_pkg::REG_CTRL)) begin
            next_st.ctrl[rosel_pkg::CTRL_FORCE] = 1'b0;
        end
        unique case (wb_adr_i)
            rosel_pkg::REG_CTRL: next_st.rdat = {26'h0, st.ctrl[5:0]};
            rosel_pkg::REG_DFLT: next_st.rdat = {16'h0, st.dflt};
            rosel_pkg::REG_STAT: next_st.rdat = {22'h0, st.excl, src.present, st.sel, st.dv[0], unit_health_o};
            rosel_pkg::REG_OUT: next_st.rdat = {16'h0, st.outs};
            default: next_st.rdat = 32'h0000_0000;
        endcase

        if (rst_i) begin
            next_st = '0;
            next_st.ctrl = rosel_pkg::CTRL_RESET;
            next_st.dflt = rosel_pkg::DFLT_RESET;
            next_st.sel = rosel_pkg::SEL_DEFAULT;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdat;
    assign out_o = st.outs;
    assign fault_report_o = st.rep;
    assign fs_fault_o = fs_cur;
    assign nl_fault_o = nl_cur;
    assign unit_health_o = any_fault == 16'h0000;
    // Only voted and failover blocks join output autotest
    assign autotest_en_o = mode == rosel_pkg::MODE_VOTED || mode == rosel_pkg::MODE_FAILOVER;
    assign voter_in_o = voted ? usable : 3'h0;
endmodule

//--- dv/rosel_ctrl_model.sv
// Behavioural model of the three redundant controllers on the station bus
`timescale 1ns/1ps
module rosel_ctrl_model #(
    parameter int SCAN = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Which stations send, and their words
    input wire logic [2:0] online_i,
    input wire logic [47:0] words_i,
    // Station bus side
    output logic scan_end_o,
    output logic [2:0] valid_o,
    output logic [47:0] data_o
);
    int cnt;
    logic hit;
    logic [47:0] m;
    assign hit = cnt == SCAN / 2;
    // Lane 0 is station 31, lane 1 is 30, lane 2 is 29
    assign m = {{16{online_i[2]}}, {16{online_i[1]}}, {16{online_i[0]}}};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            scan_end_o <= 1'b0;
            valid_o <= 3'h0;
            data_o <= 48'h0;
        end else begin
            cnt <= (cnt == SCAN - 1) ? 0 : cnt + 1;
            scan_end_o <= cnt == SCAN - 1;
            // Only controllers running with outputs enabled send
            valid_o <= hit ? online_i : 3'h0;
            // Idle lanes toggle so stale data never looks valid
            data_o <= hit ? (words_i & m) | (~data_o & ~m) : ~data_o;
        end
    end
endmodule

//--- dv/rosel_properties.sv
// Concurrent checks on the selector's ports
`timescale 1ns/1ps
module rosel_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Faults
    input wire logic [15:0] failed_switch_i,
    input wire logic [15:0] no_load_i,
    input wire logic [15:0] other_fault_i,
    input wire logic [15:0] fs_fault_o,
    input wire logic [15:0] nl_fault_o,
    input wire logic [2:0] fault_report_o
);
    // Mode mirror from accepted control writes; the fault delays apply in voted mode only
    logic voted_q;
    logic dc16_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            voted_q <= rosel_pkg::CTRL_RESET[rosel_pkg::CTRL_MODE_LSB +: 2] == 2'h0;
            dc16_q <= rosel_pkg::CTRL_RESET[rosel_pkg::CTRL_DC16];
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == rosel_pkg::REG_CTRL
                     && wb_sel_i[0]) begin
            voted_q <= wb_dat_i[rosel_pkg::CTRL_MODE_LSB +: 2] == 2'h0;
            dc16_q <= wb_dat_i[rosel_pkg::CTRL_DC16];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_fs_delayed: assert property ($rose(|failed_switch_i) && voted_q && fs_fault_o == 16'h0
        |=> (fs_fault_o == 16'h0) [*8])
        else $error("failed switch shown too early");
    a_nl_delayed: assert property ($rose(|no_load_i) && voted_q && dc16_q && nl_fault_o == 16'h0
        |=> (nl_fault_o == 16'h0) [*8])
        else $error("no load shown too early");
    a_report_pulse: assert property (fault_report_o != 3'h0 |=> fault_report_o == 3'h0)
        else $error("fault report longer than one cycle");
    a_report_dest: assert property (fault_report_o inside {3'h0, 3'h1, 3'h7})
        else $error("fault report to wrong stations");
    // Raw other faults reach the report one cycle later, switch and load faults two when voted mode does not delay or drop them
    a_report_cause: assert property (fault_report_o != 3'h0 |->
        $past(other_fault_i | failed_switch_i | no_load_i) != 16'h0
        || $past(other_fault_i | failed_switch_i | no_load_i, 2) != 16'h0)
        else $error("fault report without fault");
    c_report: cover property (fault_report_o == 3'h7);
    c_ack: cover property (wb_ack_o);
    c_noload: cover property ($rose(|no_load_i));
endmodule
bind rosel_top rosel_props i_rosel_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .failed_switch_i(failed_switch_i), .no_load_i(no_load_i), .other_fault_i(other_fault_i),
    .fs_fault_o(fs_fault_o), .nl_fault_o(nl_fault_o), .fault_report_o(fault_report_o));

//--- dv/rosel_top_bench.sv
// Self-checking bench for the redundant output source selector
`timescale 1ns/1ps
module rosel_top_bench;
    logic clk_i, rst_i, cyc, stb, we, ack, scan_end, health, at;
    logic [3:0] adr;
    logic [31:0] wdat, rdat;
    logic [2:0] valid, rep, vin, online;
    logic [47:0] data, words;
    logic [15:0] fs, nl, of, out, fsf, nlf;
    int num_errors = 0;
    int n_compared = 0;
    rosel_ctrl_model i_rosel_ctrl_model (.clk_i(clk_i), .rst_i(rst_i), .online_i(online), .words_i(words),
        .scan_end_o(scan_end), .valid_o(valid), .data_o(data));
    rosel_top i_rosel_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .scan_end_i(scan_end), .data_valid_i(valid), .data_i(data), .failed_switch_i(fs), .no_load_i(nl),
        .other_fault_i(of), .out_o(out), .unit_health_o(health), .fault_report_o(rep), .fs_fault_o(fsf),
        .nl_fault_o(nlf), .autotest_en_o(at), .voter_in_o(vin));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic report_and_stop;
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h got %h", nm, e, g);
            num_errors++;
        end
    endtask
    // Classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic scans(input int n);
        repeat (n) begin
            @(posedge clk_i);
            while (scan_end !== 1'b1) @(posedge clk_i);
        end
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end
    initial begin
        int k;
        {rst_i, cyc, stb, we, adr, wdat, fs, nl, of} = {1'b1, 87'h0};
        online = 3'h0;
        words = {16'h3333, 16'h2222, 16'h1111};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", rosel_pkg::REG_CTRL, rosel_pkg::CTRL_RESET);
        rd("dflt", rosel_pkg::REG_DFLT, {16'h0, rosel_pkg::DFLT_RESET});
        wr(4'h2, 32'hffff_ffff);
        rd("unmapped", 4'h2, 32'h0);
        wr(rosel_pkg::REG_CTRL, 32'h1);
        wr(rosel_pkg::REG_DFLT, 32'ha5a5);
        online <= 3'h3;
        scans(2);
        chk("out", 32'h1111, {16'h0, out});
        chk("autotest", 32'h1, {31'h0, at});
        // Station 31 stops, as after a checksum mismatch
        online <= 3'h2;
        scans(2);
        chk("out", 32'h1111, {16'h0, out});
        scans(1);
        chk("out", 32'h2222, {16'h0, out});
        online <= 3'h3;
        scans(1);
        chk("out", 32'h1111, {16'h0, out});
        // Voted mode on a 16-circuit block, all words agree
        words <= {3{16'h1111}};
        online <= 3'h7;
        wr(rosel_pkg::REG_CTRL, 32'h10);
        scans(2);
        chk("voters", 32'h7, {29'h0, vin});
        chk("autotest", 32'h1, {31'h0, at});
        words[31:16] <= 16'h2222;
        scans(2);
        chk("voters", 32'h5, {29'h0, vin});
        chk("out", 32'h1111, {16'h0, out});
        words[31:16] <= 16'h1111;
        scans(2);
        chk("voters", 32'h7, {29'h0, vin});
        of <= 16'h1;
        k = 0;
        while (rep === 3'h0 && k < 10) begin
            @(posedge clk_i);
            k++;
        end
        chk("report", 32'h7, {29'h0, rep});
        repeat (2) @(posedge clk_i);
        chk("health", 32'h0, {31'h0, health});
        of <= 16'h0;
        nl <= 16'hffff;
        repeat (20) @(posedge clk_i);
        chk("health", 32'h1, {31'h0, health});
        chk("nl", 32'h0, {16'h0, nlf});
        fs <= 16'h00ff;
        repeat (20) @(posedge clk_i);
        chk("fs", 32'h0, {16'h0, fsf});
        // Stations go quiet before the next scan's data slot, so no late word resets the count
        {fs, nl} <= 32'h0;
        online <= 3'h0;
        wr(rosel_pkg::REG_CTRL, 32'h1);
        scans(3);
        chk("out", 32'ha5a5, {16'h0, out});
        words <= {16'h3333, 16'h2222, 16'h1111};
        online <= 3'h4;
        scans(2);
        chk("out", 32'ha5a5, {16'h0, out});
        wr(rosel_pkg::REG_CTRL, 32'h9);
        scans(1);
        chk("out", 32'h3333, {16'h0, out});
        online <= 3'h6;
        scans(1);
        chk("out", 32'h2222, {16'h0, out});
        online <= 3'h0;
        wr(rosel_pkg::REG_CTRL, 32'hd);
        scans(3);
        chk("out", 32'h2222, {16'h0, out});
        rd("outreg", rosel_pkg::REG_OUT, 32'h2222);
        for (k = 2; k < 4; k++) begin
            wr(rosel_pkg::REG_CTRL, k);
            repeat (2) @(posedge clk_i);
            chk("autotest", 32'h0, {31'h0, at});
        end
        // Outside voted mode a fault goes to station 31 only
        of <= 16'h4;
        repeat (2) @(posedge clk_i);
        chk("report", 32'h1, {29'h0, rep});
        report_and_stop();
    end
endmodule
